// [volume_emergency_ramp_automute.sv]
// Emergency volume ramp-down, per-channel auto-mute and class-D bandwidth select
// What this block does
// - A clock error or power loss ramps volume down every 1, 2 or 4 samples, or mutes at once for code 11.
// - Each emergency update lowers volume by 4, 2, 1 or 0.5 dB by the step field, which resets to 11.
// - Emergency ramps use the emergency rate and step, never the normal soft-mute settings.
// - Bit 2 chooses independent (0) or joint (1) left/right auto-mute and resets to 1.
// - Bit 1 enables right-channel auto-mute and resets to 1.
// - Bit 0 enables left-channel auto-mute and resets to 1.
// - A channel mutes only after an unbroken zero run of its programmed length.
// - Left run length in bits 6-4 picks 11.5 ms up to 5.33 s at 96 kHz.
// - Right run length in bits 2-0 uses the same table, 011 being 266.5 ms and 110 being 2.665 s.
// - Run lengths are fixed sample counts, so durations scale with sample rate.
// - Bandwidth field in bits 6-5 selects 80, 100, 120 or 175 kHz.
`timescale 1ns/1ns
`include "amp_ctrl_params.svh"
module volume_emergency_ramp_automute
  import amp_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       clock_error,
  input  wire logic       power_loss,
  input  wire sample_in_t sample_in,
  input  wire logic [7:0] volume_in,
  output logic      [7:0] volume_out,
  output logic            emergency_active,
  output logic            left_mute,
  output logic            right_mute,
  output logic      [1:0] bandwidth_sel
);
  // ****************************************
  // Registers
  // ****************************************
  emergency_ramp_t emg_q;
  emergency_ramp_t emg_d;
  logic [7:0]      amctl_q;
  logic [7:0]      amctl_d;
  logic [7:0]      amtime_q;
  logic [7:0]      amtime_d;
  logic [7:0]      bw_q;
  logic [7:0]      bw_d;
  logic [7:0]      rdata_q;
  logic [7:0]      rdata_d;
  always_comb begin
    emg_d    = emg_q;
    amctl_d  = amctl_q;
    amtime_d = amtime_q;
    bw_d     = bw_q;
    if (reg_wr) begin
      case (reg_addr)
        `OFS_EMERGENCY_VOLUME_RAMP:    emg_d    = reg_wdata;
        `OFS_AUTO_MUTE_CONTROL:        amctl_d  = reg_wdata;
        `OFS_AUTO_MUTE_TIME:           amtime_d = reg_wdata;
        `OFS_OUTPUT_BANDWIDTH_CONTROL: bw_d     = reg_wdata;
        default:                       ;
      endcase
    end
    case (reg_addr)
      `OFS_EMERGENCY_VOLUME_RAMP:    rdata_d = emg_q;
      `OFS_AUTO_MUTE_CONTROL:        rdata_d = amctl_q;
      `OFS_AUTO_MUTE_TIME:           rdata_d = amtime_q;
      `OFS_OUTPUT_BANDWIDTH_CONTROL: rdata_d = bw_q;
      default:                       rdata_d = `RDATA_UNMAPPED;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      emg_q    <= `RST_EMERGENCY_VOLUME_RAMP;
      amctl_q  <= `RST_AUTO_MUTE_CONTROL;
      amtime_q <= `RST_AUTO_MUTE_TIME;
      bw_q     <= `RST_OUTPUT_BANDWIDTH_CONTROL;
      rdata_q  <= `RDATA_UNMAPPED;
    end else begin
      emg_q    <= emg_d;
      amctl_q  <= amctl_d;
      amtime_q <= amtime_d;
      bw_q     <= bw_d;
      rdata_q  <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;
  // ****************************************
  // Fault input synchronisers
  // ****************************************
  // Fault pins are asynchronous to clk
  logic [1:0] clkerr_sync_q;
  logic [1:0] pwrloss_sync_q;
  logic       fault;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkerr_sync_q  <= 2'h0;
      pwrloss_sync_q <= 2'h0;
    end else begin
      clkerr_sync_q  <= {clkerr_sync_q[0], clock_error};
      pwrloss_sync_q <= {pwrloss_sync_q[0], power_loss};
    end
  end
  assign fault = clkerr_sync_q[1] | pwrloss_sync_q[1];
  // ****************************************
  // Emergency ramp-down
  // ****************************************
  ramp_state_t state_q;
  ramp_state_t state_d;
  logic [7:0]  vol_q;
  logic [7:0]  vol_d;
  logic [1:0]  div_q;
  logic [1:0]  div_d;
  logic        upd_tick;
  logic [7:0]  step_amt;
  logic [8:0]  vol_sum;
  logic        act_q;
  logic        act_d;
  always_comb begin
    case (emg_q.speed)
      2'h0:    upd_tick = sample_in.valid;
      2'h1:    upd_tick = sample_in.valid && div_q[0];
      2'h2:    upd_tick = sample_in.valid && (div_q == 2'h3);
      default: upd_tick = 1'b0;
    endcase
    case (emg_q.step)
      2'h0:    step_amt = `VOL_STEP_4DB;
      2'h1:    step_amt = `VOL_STEP_2DB;
      2'h2:    step_amt = `VOL_STEP_1DB;
      default: step_amt = `VOL_STEP_HDB;
    endcase
    vol_sum = {1'b0, vol_q} + {1'b0, step_amt};
    state_d = state_q;
    vol_d   = vol_q;
    div_d   = div_q;
    case (state_q)
      RAMP_IDLE: begin
        vol_d = volume_in;
        div_d = 2'h0;
        if (fault) begin
          if (emg_q.speed == 2'h3) begin
            vol_d   = `VOL_MUTE;
            state_d = RAMP_MUTED;
          end else begin
            state_d = RAMP_DOWN;
          end
        end
      end
      RAMP_DOWN: begin
        if (sample_in.valid) begin
          div_d = div_q + 2'h1;
        end
        if (emg_q.speed == 2'h3) begin
          vol_d   = `VOL_MUTE;
          state_d = RAMP_MUTED;
        end else if (upd_tick) begin
          vol_d = vol_sum[8] ? `VOL_MUTE : vol_sum[7:0];
          if (vol_sum[8] || vol_sum[7:0] == `VOL_MUTE) begin
            vol_d   = `VOL_MUTE;
            state_d = RAMP_MUTED;
          end
        end
        if (!fault) begin
          state_d = RAMP_IDLE;
        end
      end
      RAMP_MUTED: begin
        vol_d = `VOL_MUTE;
        if (!fault) begin
          state_d = RAMP_IDLE;
        end
      end
      default: begin
        state_d = RAMP_IDLE;
        vol_d   = `VOL_MUTE;
      end
    endcase
    act_d = (state_d != RAMP_IDLE);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= RAMP_IDLE;
      vol_q   <= `VOL_MUTE;
      div_q   <= 2'h0;
      act_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      vol_q   <= vol_d;
      div_q   <= div_d;
      act_q   <= act_d;
    end
  end
  assign volume_out       = vol_q;
  assign emergency_active = act_q;
  // ****************************************
  // Auto-mute
  // ****************************************
  logic [18:0] left_len;
  logic [18:0] right_len;
  logic        left_reached;
  logic        right_reached;
  logic        left_cond;
  logic        right_cond;
  logic        lmute_q;
  logic        lmute_d;
  logic        rmute_q;
  logic        rmute_d;
  logic [1:0]  bwsel_q;
  localparam logic [18:0] run_table [8] = '{
    19'(`RUN_SAMPLES(`TIME_US_0)), 19'(`RUN_SAMPLES(`TIME_US_1)), 19'(`RUN_SAMPLES(`TIME_US_2)),
    19'(`RUN_SAMPLES(`TIME_US_3)), 19'(`RUN_SAMPLES(`TIME_US_4)), 19'(`RUN_SAMPLES(`TIME_US_5)),
    19'(`RUN_SAMPLES(`TIME_US_6)), 19'(`RUN_SAMPLES(`TIME_US_7))};
  assign left_len  = run_table[amtime_q[`LTIME_HI:`LTIME_LO]];
  assign right_len = run_table[amtime_q[`RTIME_HI:`RTIME_LO]];
  zero_run_counter left_run (
    .clk          (clk),
    .rst_n        (rst_n),
    .sample_valid (sample_in.valid),
    .sample_zero  (sample_in.left == 24'h000000),
    .run_length   (left_len),
    .run_reached  (left_reached)
  );
  zero_run_counter right_run (
    .clk          (clk),
    .rst_n        (rst_n),
    .sample_valid (sample_in.valid),
    .sample_zero  (sample_in.right == 24'h000000),
    .run_length   (right_len),
    .run_reached  (right_reached)
  );
  always_comb begin
    left_cond  = left_reached && amctl_q[`AM_L_EN_BIT];
    right_cond = right_reached && amctl_q[`AM_R_EN_BIT];
    if (amctl_q[`AM_JOINT_BIT]) begin
      lmute_d = left_cond && right_cond;
      rmute_d = left_cond && right_cond;
    end else begin
      lmute_d = left_cond;
      rmute_d = right_cond;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lmute_q <= 1'b0;
      rmute_q <= 1'b0;
      bwsel_q <= 2'h0;
    end else begin
      lmute_q <= lmute_d;
      rmute_q <= rmute_d;
      bwsel_q <= bw_q[`BW_HI:`BW_LO];
    end
  end
  assign left_mute     = lmute_q;
  assign right_mute    = rmute_q;
  assign bandwidth_sel = bwsel_q;
  // ****************************************
  // Checks
  // ****************************************
  AST_INSTANT_MUTE: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == RAMP_IDLE && fault && emg_q.speed == 2'h3 |=> volume_out == `VOL_MUTE && state_q == RAMP_MUTED)
    else $error("Instant mute code did not mute at once");
  AST_RATE_ONE: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == RAMP_DOWN && emg_q.speed == 2'h0 && !reg_wr && !sample_in.valid |=> $stable(volume_out))
    else $error("Volume moved without a sample");
  AST_STEP_SIZE: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == RAMP_DOWN && upd_tick && emg_q.step == 2'h0 && vol_q < 8'hF0 |=> volume_out == $past(vol_q) + 8'h08)
    else $error("4 dB step not applied");
  AST_FAULT_ENTERS: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == RAMP_IDLE && fault |=> emergency_active)
    else $error("Fault did not start emergency ramp");
  AST_JOINT_TOGETHER: assert property (@(posedge clk) disable iff (!rst_n)
    amctl_q[`AM_JOINT_BIT] && $stable(amctl_q) |=> left_mute == right_mute)
    else $error("Joint mode muted channels apart");
  AST_RIGHT_DISABLED: assert property (@(posedge clk) disable iff (!rst_n)
    !amctl_q[`AM_R_EN_BIT] |=> !right_mute)
    else $error("Right muted while disabled");
  AST_LEFT_DISABLED: assert property (@(posedge clk) disable iff (!rst_n)
    !amctl_q[`AM_L_EN_BIT] |=> !left_mute)
    else $error("Left muted while disabled");
  AST_INDEP_LEFT: assert property (@(posedge clk) disable iff (!rst_n)
    !amctl_q[`AM_JOINT_BIT] && amctl_q[`AM_L_EN_BIT] |=> left_mute == $past(left_reached))
    else $error("Left mute does not follow zero run");
  AST_BW_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> bandwidth_sel == $past(bw_q[`BW_HI:`BW_LO]))
    else $error("Bandwidth select lags its field");
endmodule : volume_emergency_ramp_automute

// [amp_ctrl_params.svh]
// Offsets, field positions, reset values and counts for the emergency ramp and auto-mute block
`ifndef AMP_CTRL_PARAMS_SVH
`define AMP_CTRL_PARAMS_SVH

// ****************************************
// Register offsets and reset values
// ****************************************
`define OFS_EMERGENCY_VOLUME_RAMP    8'h4F
`define OFS_AUTO_MUTE_CONTROL        8'h50
`define OFS_AUTO_MUTE_TIME           8'h51
`define OFS_OUTPUT_BANDWIDTH_CONTROL 8'h53
`define RST_EMERGENCY_VOLUME_RAMP    8'h30
`define RST_AUTO_MUTE_CONTROL        8'h07
`define RST_AUTO_MUTE_TIME           8'h00
`define RST_OUTPUT_BANDWIDTH_CONTROL 8'h00
`define RDATA_UNMAPPED               8'h00

// ****************************************
// Field positions
// ****************************************
`define EMG_SPEED_HI 7
`define EMG_SPEED_LO 6
`define EMG_STEP_HI  5
`define EMG_STEP_LO  4
`define AM_JOINT_BIT 2
`define AM_R_EN_BIT  1
`define AM_L_EN_BIT  0
`define LTIME_HI     6
`define LTIME_LO     4
`define RTIME_HI     2
`define RTIME_LO     0
`define BW_HI        6
`define BW_LO        5

// ****************************************
// Volume codes, 0.5 dB per code
// ****************************************
`define VOL_MUTE     8'hFF
`define VOL_STEP_4DB 8'h08
`define VOL_STEP_2DB 8'h04
`define VOL_STEP_1DB 8'h02
`define VOL_STEP_HDB 8'h01

// ****************************************
// Zero-run lengths, microseconds at the reference rate
// ****************************************
`define REF_RATE_KHZ 96
`define TIME_US_0    11500
`define TIME_US_1    53000
`define TIME_US_2    106500
`define TIME_US_3    266500
`define TIME_US_4    535000
`define TIME_US_5    1065000
`define TIME_US_6    2665000
`define TIME_US_7    5330000
`define RUN_SAMPLES(us) ((us) * `REF_RATE_KHZ / 1000)

`endif

// [amp_ctrl_pkg.sv]
// Types shared by the emergency ramp and auto-mute block
package amp_ctrl_pkg;
  typedef struct packed {
    logic [1:0] speed;
    logic [1:0] step;
    logic [3:0] rsvd;
  } emergency_ramp_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] left;
    logic [23:0] right;
  } sample_in_t;

  typedef enum logic [2:0] {
    RAMP_IDLE  = 3'b001,
    RAMP_DOWN  = 3'b010,
    RAMP_MUTED = 3'b100
  } ramp_state_t;
endpackage : amp_ctrl_pkg

// [zero_run_counter.sv]
// Counter of consecutive zero samples on one channel
`timescale 1ns/1ns
module zero_run_counter (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        sample_valid,
  input  wire logic        sample_zero,
  input  wire logic [18:0] run_length,
  output logic             run_reached
);
  logic [18:0] count_q;
  logic [18:0] count_d;
  logic        reached_q;
  logic        reached_d;

  always_comb begin
    count_d   = count_q;
    reached_d = reached_q;
    if (sample_valid) begin
      if (!sample_zero) begin
        count_d   = 19'h00000;
        reached_d = 1'b0;
      end else if (count_q < run_length) begin
        count_d   = count_q + 19'h00001;
        reached_d = (count_q + 19'h00001) >= run_length;
      end else begin
        reached_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q   <= 19'h00000;
      reached_q <= 1'b0;
    end else begin
      count_q   <= count_d;
      reached_q <= reached_d;
    end
  end

  assign run_reached = reached_q;

  AST_NONZERO_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
    sample_valid && !sample_zero |=> !run_reached && count_q == 19'h00000)
    else $error("Nonzero sample did not restart zero run");
  AST_REACHED_NEEDS_RUN: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(run_reached) |-> $past(sample_valid) && $past(sample_zero) && count_q >= run_length)
    else $error("Zero run flagged before programmed length");
endmodule : zero_run_counter

// [tb_volume_emergency_ramp_automute.sv]
// Self-checking bench for the emergency ramp, auto-mute and bandwidth block
`timescale 1ns/1ns
module tb_volume_emergency_ramp_automute import amp_ctrl_pkg::*; ();
  typedef struct packed {
    logic [2:0] sel;
    logic [7:0] val;
  } note_t;

  logic       clk;
  logic       rst_n;
  logic       reg_wr;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       clock_error;
  logic       power_loss;
  sample_in_t sample_in;
  logic [7:0] volume_in;
  logic [7:0] volume_out;
  logic       emergency_active;
  logic       left_mute;
  logic       right_mute;
  logic [1:0] bandwidth_sel;
  int         mismatches;
  int         comparisons;
  note_t      notes[$];
  note_t      n;
  logic [7:0] obs;
  logic [7:0] d;
  logic [7:0] ofs[4] = '{8'h4F, 8'h50, 8'h51, 8'h53};
  event       chk_ev;

  volume_emergency_ramp_automute i_dut (
    .clk, .rst_n, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .clock_error, .power_loss,
    .sample_in, .volume_in, .volume_out, .emergency_active, .left_mute, .right_mute, .bandwidth_sel
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****************************************
  // Note queue and output watcher
  // ****************************************
  task automatic expect_out(input logic [2:0] sel, input logic [7:0] val);
    notes.push_back({sel, val});
    -> chk_ev;
    #1;
  endtask : expect_out

  initial forever begin
    @(chk_ev);
    n = notes.pop_front();
    obs = (n.sel == 3'd0) ? reg_rdata : (n.sel == 3'd1) ? volume_out :
          (n.sel == 3'd2) ? {7'h00, emergency_active} :
          (n.sel == 3'd3) ? {6'h00, left_mute, right_mute} : {6'h00, bandwidth_sel};
    comparisons++;
    if (obs !== n.val) begin
      mismatches++;
      $display("ERROR %0t: output %0d is %h, expected %h", $time, n.sel, obs, n.val);
    end
  end

  task automatic test_done;
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // Whole run needs well under this many cycles
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    test_done();
  end

  // ****************************************
  // Stimulus tasks, all driven on the falling edge
  // ****************************************
  task automatic wait_n(input int k);
    repeat (k) @(negedge clk);
  endtask : wait_n

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    expect_out(3'd0, e);
  endtask : rd

  // Nonzero samples are random but never zero, so a run is only broken on purpose
  task automatic samp(input int k, input logic lz, input logic rz);
    repeat (k) begin
      @(negedge clk);
      sample_in.valid = 1'b1;
      sample_in.left = lz ? 24'h000000 : (24'($urandom) | 24'h000001);
      sample_in.right = rz ? 24'h000000 : (24'($urandom) | 24'h000001);
    end
    @(negedge clk);
    sample_in.valid = 1'b0;
  endtask : samp

  task automatic chk_mute(input logic l, input logic r);
    wait_n(2);
    expect_out(3'd3, {6'h00, l, r});
  endtask : chk_mute

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    clock_error = 1'b0;
    power_loss = 1'b0;
    sample_in = '0;
    volume_in = 8'h40;
    mismatches = 0;
    comparisons = 0;
    void'($urandom(41));
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    // Volume only follows its input from the first edge after release
    wait_n(1);
    expect_out(3'd1, 8'h40);
    rd(8'h4F, 8'h30);
    rd(8'h50, 8'h07);
    rd(8'h51, 8'h00);
    rd(8'h53, 8'h00);
    wr(8'h52, 8'hFF);
    rd(8'h52, 8'h00);
    foreach (ofs[i]) begin
      d = 8'($urandom);
      wr(ofs[i], d);
      rd(ofs[i], d);
    end
    for (int b = 0; b < 4; b++) begin
      wr(8'h53, {1'b0, 2'(b), 5'h1F});
      wait_n(2);
      expect_out(3'd4, 8'(b));
    end
    // Every rate and step, faults from both sources; normal volume moves meanwhile
    for (int sp = 0; sp < 4; sp++) begin
      for (int st = 0; st < 4; st++) begin
        wr(8'h4F, {2'(sp), 2'(st), 4'h0});
        volume_in = 8'h40;
        if (st % 2 == 1) clock_error = 1'b1;
        else power_loss = 1'b1;
        wait_n(4);
        expect_out(3'd2, 8'h01);
        expect_out(3'd1, (sp == 3) ? 8'hFF : 8'h40);
        volume_in = 8'($urandom);
        if (sp < 3) begin
          samp(2 * (1 << sp) - 1, 1'b0, 1'b0);
          wait_n(1);
          expect_out(3'd1, 8'h40 + 8'(8 >> st));
          samp(1, 1'b0, 1'b0);
          wait_n(1);
          expect_out(3'd1, 8'h40 + 8'(16 >> st));
        end
        clock_error = 1'b0;
        power_loss = 1'b0;
        wait_n(4);
        expect_out(3'd2, 8'h00);
        expect_out(3'd1, volume_in);
      end
    end
    // Largest step must stop at full mute, not wrap
    wr(8'h4F, 8'h00);
    volume_in = 8'hFC;
    clock_error = 1'b1;
    wait_n(4);
    samp(1, 1'b0, 1'b0);
    wait_n(1);
    expect_out(3'd1, 8'hFF);
    clock_error = 1'b0;
    wait_n(4);
    // Shortest run, independent channels
    wr(8'h51, 8'h00);
    wr(8'h50, 8'h03);
    samp(1000, 1'b1, 1'b1);
    samp(1, 1'b0, 1'b1);
    samp(1103, 1'b1, 1'b0);
    chk_mute(1'b0, 1'b0);
    samp(1, 1'b1, 1'b0);
    chk_mute(1'b1, 1'b0);
    samp(1, 1'b0, 1'b0);
    chk_mute(1'b0, 1'b0);
    // Joint mode waits for both channels, then each enable bit alone in independent mode
    wr(8'h50, 8'h07);
    samp(1104, 1'b1, 1'b0);
    chk_mute(1'b0, 1'b0);
    samp(1104, 1'b1, 1'b1);
    chk_mute(1'b1, 1'b1);
    samp(1, 1'b1, 1'b0);
    chk_mute(1'b0, 1'b0);
    wr(8'h50, 8'h02);
    samp(1104, 1'b1, 1'b1);
    chk_mute(1'b0, 1'b1);
    wr(8'h50, 8'h01);
    chk_mute(1'b1, 1'b0);
    // Longer codes on each field, exact sample counts
    wr(8'h50, 8'h03);
    wr(8'h51, 8'h13);
    samp(1, 1'b0, 1'b0);
    samp(5087, 1'b1, 1'b1);
    chk_mute(1'b0, 1'b0);
    samp(1, 1'b1, 1'b1);
    chk_mute(1'b1, 1'b0);
    samp(20495, 1'b1, 1'b1);
    chk_mute(1'b1, 1'b0);
    samp(1, 1'b1, 1'b1);
    chk_mute(1'b1, 1'b1);
    // Reset mid-run restores defaults and drops mutes
    rst_n = 1'b0;
    wait_n(2);
    rst_n = 1'b1;
    chk_mute(1'b0, 1'b0);
    rd(8'h51, 8'h00);
    rd(8'h50, 8'h07);
    test_done();
  end
endmodule : tb_volume_emergency_ramp_automute
